// ### dv/scaux_chk.sv
module scaux_chk
	import scaux_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        RESET_N,
	input wire logic [7:0]  NARROW_IN,
	input wire logic [13:0] NARROW_OUT,
	input wire logic        STATUS_WR,
	input wire logic        STATUS_OUT,
	input wire logic        SHORT_BRANCH_INSTR,
	input wire logic        LONG_BRANCH_INSTR,
	input wire logic        CALL_INSTR,
	input wire logic        BRANCH_TAKEN,
	input wire logic        INT_ENTER,
	input wire logic        RETURN_FROM_INTERRUPT_INSTR,
	input wire logic        SET_INTEGER_MODE_INSTR,
	input wire logic        SET_SIGN_EXTEND_INSTR,
	input wire logic        INT_MODE_OUT,
	input wire logic        LOAD_TIMER_INSTR,
	input wire logic [7:0]  TIMER_OUT,
	input wire logic        L2_REQ,
	input wire logic        SAMPLE_TICK,
	input wire logic        L1_REQ,
	input wire logic        BIT_EXTRACT_INSTR,
	input wire logic        GET_DONE,
	input wire logic        GET_BUSY,
	input wire logic        FETCH_REQ
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking dc @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	// Flag copies at interrupt entry
	logic sv_st_q, sv_im_q, tld_q;
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			sv_st_q <= 1'b0;
			sv_im_q <= 1'b0;
		end else if (INT_ENTER) begin
			sv_st_q <= STATUS_OUT;
			sv_im_q <= INT_MODE_OUT;
		end
	end
	// Timer loaded mark, cleared by reset like the design's
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			tld_q <= 1'b0;
		else if (LOAD_TIMER_INSTR)
			tld_q <= 1'b1;
	end

	// Sequences; s_wrap and s_refill are multi-step, s_take is a single step
	sequence s_wrap;
		!LOAD_TIMER_INSTR ##1 $past(TIMER_OUT) == 8'h00 && TIMER_OUT == 8'hff;
	endsequence
	sequence s_take;
		BIT_EXTRACT_INSTR && !GET_BUSY;
	endsequence
	sequence s_refill;
		FETCH_REQ && GET_BUSY ##1 GET_DONE;
	endsequence

	property p_branch;
		BRANCH_TAKEN == (STATUS_OUT && (SHORT_BRANCH_INSTR
			|| LONG_BRANCH_INSTR || CALL_INSTR));
	endproperty
	a_branch: assert property (p_branch)
		else $error("branch taken disagrees with status");
	property p_restore;
		RETURN_FROM_INTERRUPT_INSTR && !INT_ENTER && !STATUS_WR
			&& !SET_INTEGER_MODE_INSTR && !SET_SIGN_EXTEND_INSTR
			|=> STATUS_OUT == sv_st_q && INT_MODE_OUT == sv_im_q;
	endproperty
	a_restore: assert property (p_restore)
		else $error("flags not restored on return");
	property p_int_set;
		SET_INTEGER_MODE_INSTR && !SET_SIGN_EXTEND_INSTR
			&& !RETURN_FROM_INTERRUPT_INSTR |=> INT_MODE_OUT;
	endproperty
	a_int_set: assert property (p_int_set)
		else $error("integer mode not set");
	property p_narrow;
		NARROW_OUT == (INT_MODE_OUT ? {6'h00, NARROW_IN}
			: {{6{NARROW_IN[7]}}, NARROW_IN});
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("narrow operand widened wrongly");
	property p_tmr_step;
		!LOAD_TIMER_INSTR |=> TIMER_OUT == $past(TIMER_OUT)
			|| TIMER_OUT == $past(TIMER_OUT) - 8'h01;
	endproperty
	a_tmr_step: assert property (p_tmr_step)
		else $error("timer moved by more than one");
	property p_l2_post;
		s_wrap |-> ##[0:1] L2_REQ;
	endproperty
	a_l2_post: assert property (p_l2_post)
		else $error("timer wrap without level-2 request");
	property p_tmr_idle;
		!tld_q && !LOAD_TIMER_INSTR |=> TIMER_OUT == 8'h00;
	endproperty
	a_tmr_idle: assert property (p_tmr_idle)
		else $error("timer moved before first load");
	property p_l1;
		L1_REQ |-> $past(SAMPLE_TICK);
	endproperty
	a_l1: assert property (p_l1)
		else $error("level-1 request without sample");
	property p_get;
		s_take |=> GET_DONE or s_refill;
	endproperty
	a_get: assert property (p_get)
		else $error("extract not completed in time");
endmodule // scaux_chk

// ### dv/tb_scaux_top.sv
module tb_scaux_top
	import scaux_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        REF_CLK, RESET_N, REG_WR, REG_RD, STATUS_IN, FETCH_REQ;
	logic        STATUS_OUT, BRANCH_TAKEN, INT_MODE_OUT, L2_REQ, L1_REQ;
	logic        EXCITE_OUT, GET_DONE, GET_BUSY, bt;
	logic [3:0]  REG_ADDR, BIT_COUNT;
	logic [13:0] REG_WDATA, ACC_IN, REG_RDATA, NARROW_OUT, FETCH_ADDR, fa;
	logic [7:0]  IDX_IN, NARROW_IN, TIMER_OUT, GET_DATA;
	wire logic [7:0] FETCH_DATA;
	logic [1:0]  FETCH_SRC, fs;
	logic [15:0] s;
	int          err_total, check_count;
	wire logic   STATUS_WR, SHORT_BRANCH_INSTR, LONG_BRANCH_INSTR, CALL_INSTR;
	wire logic   INT_ENTER, RETURN_FROM_INTERRUPT_INSTR, SAMPLE_TICK, L2_ACK;
	wire logic   SET_INTEGER_MODE_INSTR, SET_SIGN_EXTEND_INSTR, SPEECH_START;
	wire logic   LOAD_TIMER_INSTR, LOAD_PRESCALER_INSTR, LOAD_PITCH_INSTR;
	wire logic   LOAD_UNPACKER_INSTR, BIT_EXTRACT_INSTR;
	localparam int WST = 0, BSH = 1, BCL = 3, IEN = 4, IRT = 5, MIN = 6;
	localparam int MSX = 7, TLD = 8, PLD = 9, ACK = 10, PIT = 11, SST = 12;
	localparam int TCK = 13, ULD = 14, XTR = 15;

	// One strobe bit per instruction input
	assign {BIT_EXTRACT_INSTR, LOAD_UNPACKER_INSTR, SAMPLE_TICK, SPEECH_START,
		LOAD_PITCH_INSTR, L2_ACK, LOAD_PRESCALER_INSTR, LOAD_TIMER_INSTR,
		SET_SIGN_EXTEND_INSTR, SET_INTEGER_MODE_INSTR,
		RETURN_FROM_INTERRUPT_INSTR, INT_ENTER, CALL_INSTR, LONG_BRANCH_INSTR,
		SHORT_BRANCH_INSTR, STATUS_WR} = s;

	scaux_top scaux_top_i (.*);

	// Clock at 125 MHz
	initial begin
		REF_CLK = 1'b0;
		forever #4 REF_CLK = ~REF_CLK;
	end

	// Byte source answers while the request stands, where the unpacker
	// samples it; idle shows the inverse so a mistimed sample cannot pass
	assign FETCH_DATA = FETCH_REQ ? FETCH_ADDR[7:0] ^ 8'h5a
		: ~(FETCH_ADDR[7:0] ^ 8'h5a);
	always @(posedge REF_CLK) begin
		if (FETCH_REQ) begin
			fa <= FETCH_ADDR;
			fs <= FETCH_SRC;
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Strobe with operand levels; branch outcome caught mid-strobe
	task automatic pulse(input int k, input logic [13:0] d);
		@(posedge REF_CLK);
		s[k] <= 1'b1;
		ACC_IN <= d;
		BIT_COUNT <= d[3:0];
		STATUS_IN <= d[0];
		NARROW_IN <= d[7:0];
		IDX_IN <= ~d[7:0];
		#1 bt = BRANCH_TAKEN;
		@(posedge REF_CLK);
		s[k] <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [13:0] d);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [13:0] e);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		#1 chk(REG_RDATA, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask

	// Edges until the timer output moves, bounded
	task automatic wait_chg(output int n);
		logic [7:0] v;
		v = TIMER_OUT;
		n = 0;
		do begin
			@(posedge REF_CLK);
			#1 n++;
		end while (TIMER_OUT === v && n < 200);
	endtask

	task automatic get_bits(input int n, input logic [7:0] e);
		pulse(XTR, 14'(n));
		for (int i = 0; i < 3 && GET_DONE !== 1'b1; i++) begin
			@(posedge REF_CLK);
			#1;
		end
		chk(14'(GET_DATA), 14'(e));
	endtask

	task automatic tk(input logic [13:0] ep, input logic el);
		pulse(TCK, 14'h0000);
		chk(14'(L1_REQ), 14'(el));
		rd(ADDR_PPC, ep);
	endtask

	// Watchdog, far beyond the thousand or so cycles needed
	initial begin
		repeat (20000) @(posedge REF_CLK);
		err_total++;
		$display("mismatch at %0t: run did not finish", $time);
		give_verdict();
	end

	initial begin
		int n;
		RESET_N = 1'b0;
		s = '0;
		{REG_WR, REG_RD, STATUS_IN, REG_ADDR, BIT_COUNT} = '0;
		{REG_WDATA, ACC_IN, IDX_IN, NARROW_IN} = '0;
		repeat (6) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		rd(ADDR_FLAGS, 14'h0000);
		rd(4'hf, 14'h0000);
		pulse(MIN, 14'h0080);
		chk(NARROW_OUT, 14'h0080);
		for (int st = 0; st < 2; st++) begin
			pulse(WST, 14'(st));
			for (int k = BSH; k <= BCL; k++) begin
				pulse(k, 14'h0000);
				chk(14'(bt), 14'(st));
			end
		end
		pulse(IEN, 14'h0000);
		pulse(WST, 14'h0000);
		pulse(MSX, 14'h0080);
		chk(NARROW_OUT, 14'h3f80);
		pulse(IRT, 14'h0000);
		rd(ADDR_FLAGS, 14'h0003);
		pulse(PLD, 14'h0002);
		idle(600);
		chk(14'(TIMER_OUT), 14'h0000);
		chk(14'(L2_REQ), 14'h0000);
		pulse(TLD, 14'h0000);
		wait_chg(n);
		chk(14'(TIMER_OUT), 14'h00ff);
		idle(1);
		chk(14'(L2_REQ), 14'h0001);
		pulse(ACK, 14'h0000);
		chk(14'(L2_REQ), 14'h0000);
		wait_chg(n);
		wait_chg(n);
		chk(14'(n), 14'd48);
		pulse(PLD, 14'h0000);
		wait_chg(n);
		chk(14'(n), 14'd46);
		wait_chg(n);
		chk(14'(n), 14'd16);
		wr(ADDR_MODE, 14'h0002);
		rd(ADDR_MODE, 14'h0002);
		pulse(PIT, 14'h0240);
		pulse(SST, 14'h0000);
		rd(ADDR_PITCH, 14'h0240);
		rd(ADDR_PPC, 14'h0000);
		tk(14'h0220, 1'b0);
		tk(14'h0200, 1'b0);
		tk(14'h01e0, 1'b1);
		for (int v = 'h1c0; v >= 'h160; v -= 'h20) begin
			tk(14'(v), 1'b0);
		end
		chk(14'(EXCITE_OUT), 14'h0000);
		tk(14'h0140, 1'b0);
		tk(14'h0120, 1'b0);
		chk(14'(EXCITE_OUT), 14'h0001);
		for (int v = 'h100; v >= 0; v -= 'h20) begin
			tk(14'(v), 1'b0);
		end
		pulse(PIT, 14'h0100);
		tk(14'h00e0, 1'b1);
		pulse(ULD, 14'h0123);
		idle(2);
		chk(fa, 14'h0123);
		chk(14'(fs), 14'h0000);
		get_bits(3, 8'h03);
		get_bits(5, 8'h19);
		chk(fa, 14'h0124);
		rd(ADDR_SAR, 14'h0125);
		get_bits(8, 8'h7e);
		wr(ADDR_MODE, 14'h0022);
		pulse(ULD, 14'h0123);
		idle(2);
		chk(fa, 14'h00dc);
		chk(14'(fs), 14'h0001);
		get_bits(8, 8'h86);
		chk(fa, 14'h00f7);
		rd(ADDR_SAR, 14'h0124);
		wr(ADDR_MODE, 14'h0012);
		pulse(ULD, 14'h0200);
		idle(2);
		chk(14'(fs), 14'h0002);
		// Mid-run reset: flags, timer arming and LPC mode start over
		@(posedge REF_CLK);
		RESET_N <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		idle(100);
		chk(14'(TIMER_OUT), 14'h0000);
		chk(14'(EXCITE_OUT), 14'h0000);
		rd(ADDR_FLAGS, 14'h0000);
		give_verdict();
	end
endmodule // tb_scaux_top

bind scaux_top scaux_chk scaux_chk_i (.*);

// ### rtl/scaux_pkg.sv
package scaux_pkg;
	// Internal tick divider
	localparam int         TICK_DIV        = 16;
	// Pitch period counter figures
	localparam logic [13:0] PPC_STEP        = 14'h0020;
	localparam logic [13:0] PPC_IRQ_LIM     = 14'h0200;
	localparam logic [13:0] PPC_EXC_LIM     = 14'h0140;
	// Mode register bit positions
	localparam int         MODE_LPC_BIT    = 1;
	localparam int         MODE_EXTERNAL_ROM_ENABLE_BIT_BIT = 4;
	localparam int         MODE_RAM_SOURCE_SELECT_BIT_BIT = 5;
	localparam logic [7:0] MODE_RESET      = 8'h00;
	// Register port word addresses
	localparam logic [3:0] ADDR_MODE       = 4'h0;
	localparam logic [3:0] ADDR_TIMER      = 4'h1;
	localparam logic [3:0] ADDR_PITCH      = 4'h2;
	localparam logic [3:0] ADDR_PPC        = 4'h3;
	localparam logic [3:0] ADDR_SAR        = 4'h4;
	localparam logic [3:0] ADDR_FLAGS      = 4'h5;
	localparam logic [3:0] ADDR_UNPACK     = 4'h6;
	// Bits per unpacking byte
	localparam logic [3:0] UNPACK_BITS     = 4'h8;
	// Fetch source codes
	typedef enum logic [1:0] {
		SRC_ROM,
		SRC_RAM,
		SRC_EXT
	} scaux_src_t;
	// Unpacker states
	typedef enum logic {
		UP_IDLE,
		UP_WAIT
	} scaux_up_t;
endpackage

// ### rtl/scaux_timer.sv
module scaux_timer
	import scaux_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       load_timer,
	input  wire logic       load_prescaler,
	input  wire logic [7:0] load_val,
	input  wire logic       l2_ack,
	output logic [7:0]      timer_q,
	output logic [7:0]      psc_q,
	output logic            l2_req_q
);
	logic [3:0] div_q;
	logic       tick;
	logic [7:0] preset_q;
	logic       loaded_q;
	logic       psc_wrap;
	logic       tmr_wrap;

	// Sixteen-cycle tick divider
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			div_q <= 4'h0;
		else
			div_q <= div_q + 4'h1;
	end
	assign tick = (div_q == 4'(TICK_DIV - 1));

	// Wrap events, timer gated until first load
	assign psc_wrap = tick && (psc_q == 8'h00);
	assign tmr_wrap = psc_wrap && loaded_q && (timer_q == 8'h00);

	// Preset latch
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			preset_q <= 8'h00;
		else if (load_prescaler)
			preset_q <= load_val;
	end

	// Prescaler counter; direct write only before timer init
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			psc_q <= 8'h00;
		else if (load_prescaler && !loaded_q)
			psc_q <= load_val;
		else if (psc_wrap)
			psc_q <= preset_q;
		else if (tick)
			psc_q <= psc_q - 8'h01;
	end

	// Once loaded, the timer keeps running until reset
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			loaded_q <= 1'b0;
		else if (load_timer)
			loaded_q <= 1'b1;
	end

	// Timer; a load beats a same-cycle decrement
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			timer_q <= 8'h00;
		else if (load_timer)
			timer_q <= load_val;
		else if (psc_wrap && loaded_q)
			timer_q <= timer_q - 8'h01;
	end

	// Pending request; a new wrap wins over the acknowledge
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			l2_req_q <= 1'b0;
		else if (tmr_wrap)
			l2_req_q <= 1'b1;
		else if (l2_ack)
			l2_req_q <= 1'b0;
	end
endmodule // scaux_timer

// ### rtl/scaux_top.sv
// Added by the designer: the register addresses and strobed register access.
module scaux_top
	import scaux_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	// Register port
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [13:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [13:0]      REG_RDATA,
	// Sequencer data
	input  wire logic [13:0] ACC_IN,
	input  wire logic [7:0]  IDX_IN,
	input  wire logic [7:0]  NARROW_IN,
	output logic [13:0]      NARROW_OUT,
	// Status flag and branches
	input  wire logic        STATUS_WR,
	input  wire logic        STATUS_IN,
	output logic             STATUS_OUT,
	input  wire logic        SHORT_BRANCH_INSTR,
	input  wire logic        LONG_BRANCH_INSTR,
	input  wire logic        CALL_INSTR,
	output logic             BRANCH_TAKEN,
	// Interrupt entry and return
	input  wire logic        INT_ENTER,
	input  wire logic        RETURN_FROM_INTERRUPT_INSTR,
	// Arithmetic mode
	input  wire logic        SET_INTEGER_MODE_INSTR,
	input  wire logic        SET_SIGN_EXTEND_INSTR,
	output logic             INT_MODE_OUT,
	// Timer
	input  wire logic        LOAD_TIMER_INSTR,
	input  wire logic        LOAD_PRESCALER_INSTR,
	input  wire logic        L2_ACK,
	output logic [7:0]       TIMER_OUT,
	output logic             L2_REQ,
	// Pitch
	input  wire logic        LOAD_PITCH_INSTR,
	input  wire logic        SPEECH_START,
	input  wire logic        SAMPLE_TICK,
	output logic             L1_REQ,
	output logic             EXCITE_OUT,
	// Unpacker
	input  wire logic        LOAD_UNPACKER_INSTR,
	input  wire logic        BIT_EXTRACT_INSTR,
	input  wire logic [3:0]  BIT_COUNT,
	output logic [7:0]       GET_DATA,
	output logic             GET_DONE,
	output logic             GET_BUSY,
	// Byte fetch; data sampled while the request stands
	output logic             FETCH_REQ,
	output logic [1:0]       FETCH_SRC,
	output logic [13:0]      FETCH_ADDR,
	input  wire logic [7:0]  FETCH_DATA
);
	// Flag state
	logic        status_q;
	logic        int_mode_q;
	logic        sv_status_q;
	logic        sv_int_mode_q;
	logic [7:0]  mode_q;
	logic [13:0] rdata_q;

	// Timer state
	logic [7:0]  timer_val;
	logic        l2_req;

	// Pitch state
	logic [13:0] pitch_q;
	logic [13:0] ppc_q;
	logic [13:0] ppc_d;
	logic [14:0] ppc_diff;
	logic        ppc_pass;
	logic        l1_q;
	logic        lpc_on;

	// Unpacker state
	scaux_up_t   up_q;
	logic [7:0]  sh_q;
	logic [3:0]  left_q;
	logic [3:0]  need_q;
	logic [7:0]  part_q;
	logic        get_pend_q;
	logic [13:0] sar_q;
	logic        freq_q;
	scaux_src_t  fsrc_q;
	logic [13:0] faddr_q;
	logic [7:0]  get_data_q;
	logic        get_done_q;
	scaux_src_t  src_sel;
	logic        get_go;
	logic        get_short;
	logic        up_fill;

	// Narrow operand widening for A and B transfers
	function automatic logic [13:0] widen(
		input logic [7:0] d,
		input logic       int_mode
	);
		if (int_mode)
			widen = {6'h00, d};
		else
			widen = {{6{d[7]}}, d};
	endfunction

	// Top n bits of a byte, right justified; n of zero gives zero
	function automatic logic [7:0] take_bits(
		input logic [7:0] v,
		input logic [3:0] n
	);
		take_bits = v >> (UNPACK_BITS - n);
	endfunction

	assign NARROW_OUT = widen(NARROW_IN, int_mode_q);

	// Status flag: set by instructions, restored on return
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			status_q <= 1'b0;
		else if (RETURN_FROM_INTERRUPT_INSTR)
			status_q <= sv_status_q;
		else if (STATUS_WR)
			status_q <= STATUS_IN;
	end

	// Integer mode flag
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			int_mode_q <= 1'b0;
		else if (RETURN_FROM_INTERRUPT_INSTR)
			int_mode_q <= sv_int_mode_q;
		else if (SET_INTEGER_MODE_INSTR)
			int_mode_q <= 1'b1;
		else if (SET_SIGN_EXTEND_INSTR)
			int_mode_q <= 1'b0;
	end

	// Single save slot; nesting is the controller's concern
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			sv_status_q   <= 1'b0;
			sv_int_mode_q <= 1'b0;
		end else if (INT_ENTER) begin
			sv_status_q   <= status_q;
			sv_int_mode_q <= int_mode_q;
		end
	end

	assign STATUS_OUT   = status_q;
	assign INT_MODE_OUT = int_mode_q;

	// Conditional branch decision, combinational for the sequencer
	assign BRANCH_TAKEN = status_q &&
		(SHORT_BRANCH_INSTR || LONG_BRANCH_INSTR || CALL_INSTR);

	// Mode register, written through the register port
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			mode_q <= MODE_RESET;
		else if (REG_WR && REG_ADDR == ADDR_MODE)
			mode_q <= REG_WDATA[7:0];
	end

	assign lpc_on = mode_q[MODE_LPC_BIT];

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			rdata_q <= 14'h0000;
		else if (REG_RD) begin
			unique case (REG_ADDR)
				ADDR_MODE:   rdata_q <= {6'h00, mode_q};
				ADDR_TIMER:  rdata_q <= {6'h00, timer_val};
				ADDR_PITCH:  rdata_q <= pitch_q;
				ADDR_PPC:    rdata_q <= ppc_q;
				ADDR_SAR:    rdata_q <= sar_q;
				ADDR_FLAGS:  rdata_q <= {11'h000, l2_req, int_mode_q,
					status_q};
				ADDR_UNPACK: rdata_q <= {2'h0, left_q, sh_q};
				default:     rdata_q <= 14'h0000;
			endcase
		end else
			rdata_q <= 14'h0000;
	end

	assign REG_RDATA = rdata_q;

	// Timer and prescaler
	scaux_timer u_timer (
		.ref_clk        (REF_CLK),
		.reset_n        (RESET_N),
		.load_timer     (LOAD_TIMER_INSTR),
		.load_prescaler (LOAD_PRESCALER_INSTR),
		.load_val       (ACC_IN[7:0]),
		.l2_ack         (L2_ACK),
		.timer_q        (timer_val),
		.psc_q          (),
		.l2_req_q       (l2_req)
	);

	assign TIMER_OUT = timer_val;
	assign L2_REQ    = l2_req;

	// Pitch register; software keeps the accumulator end bits clear
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			pitch_q <= 14'h0000;
		else if (LOAD_PITCH_INSTR)
			pitch_q <= ACC_IN;
	end

	// Next period count: step down, reload by the pitch past zero
	always_comb begin
		ppc_diff = {1'b0, ppc_q} - {1'b0, PPC_STEP};
		ppc_pass = ppc_diff[14];
		if (ppc_pass)
			ppc_d = ppc_diff[13:0] + pitch_q;
		else
			ppc_d = ppc_diff[13:0];
	end

	// Pitch period counter, only stepped in LPC mode
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			ppc_q <= 14'h0000;
		else if (SPEECH_START)
			ppc_q <= 14'h0000;
		else if (SAMPLE_TICK && lpc_on)
			ppc_q <= ppc_d;
	end

	// Level-1 pulse on crossing below the limit or a low reload
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			l1_q <= 1'b0;
		else if (SAMPLE_TICK && lpc_on && !SPEECH_START)
			l1_q <= (ppc_d < PPC_IRQ_LIM) &&
				(ppc_pass || ppc_q >= PPC_IRQ_LIM);
		else
			l1_q <= 1'b0;
	end

	assign L1_REQ = l1_q;

	// Excitation window; a pitch under 0x140 cuts the pulse short
	assign EXCITE_OUT = lpc_on && (ppc_q <= PPC_EXC_LIM);

	// Source select: RAM bit dominates the external ROM bit
	always_comb begin
		if (mode_q[MODE_RAM_SOURCE_SELECT_BIT_BIT])
			src_sel = SRC_RAM;
		else if (mode_q[MODE_EXTERNAL_ROM_ENABLE_BIT_BIT])
			src_sel = SRC_EXT;
		else
			src_sel = SRC_ROM;
	end

	// Extract request decode
	assign get_go    = BIT_EXTRACT_INSTR && (up_q == UP_IDLE);
	assign get_short = BIT_COUNT < left_q;
	assign up_fill   = (up_q == UP_WAIT);
	assign GET_BUSY  = up_fill;

	// Unpacker sequence: one fetch in flight at a time
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			up_q <= UP_IDLE;
		else begin
			unique case (up_q)
				UP_IDLE:
					if (LOAD_UNPACKER_INSTR || (get_go && !get_short))
						up_q <= UP_WAIT;
				UP_WAIT:
					up_q <= UP_IDLE;
			endcase
		end
	end

	// Fetch issue; pointer advances for ROM and external ROM refills, not RAM ones
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			freq_q  <= 1'b0;
			fsrc_q  <= SRC_ROM;
			faddr_q <= 14'h0000;
			sar_q   <= 14'h0000;
		end else if (up_q == UP_IDLE && LOAD_UNPACKER_INSTR) begin
			freq_q  <= 1'b1;
			fsrc_q  <= src_sel;
			sar_q   <= ACC_IN + 14'h0001;
			if (src_sel == SRC_RAM)
				faddr_q <= {6'h00, IDX_IN};
			else
				faddr_q <= ACC_IN;
		end else if (get_go && !get_short) begin
			freq_q <= 1'b1;
			fsrc_q <= src_sel;
			if (src_sel == SRC_RAM)
				faddr_q <= {6'h00, IDX_IN};
			else begin
				faddr_q <= sar_q;
				sar_q   <= sar_q + 14'h0001;
			end
		end else
			freq_q <= 1'b0;
	end

	assign FETCH_REQ  = freq_q;
	assign FETCH_SRC  = fsrc_q;
	assign FETCH_ADDR = faddr_q;

	// Shift register, bit count and partial result
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			sh_q       <= 8'h00;
			left_q     <= 4'h0;
			need_q     <= 4'h0;
			part_q     <= 8'h00;
			get_pend_q <= 1'b0;
		end else if (up_q == UP_IDLE && LOAD_UNPACKER_INSTR) begin
			left_q     <= 4'h0;
			need_q     <= 4'h0;
			part_q     <= 8'h00;
			get_pend_q <= 1'b0;
		end else if (get_go && get_short) begin
			sh_q   <= sh_q << BIT_COUNT;
			left_q <= left_q - BIT_COUNT;
		end else if (get_go) begin
			part_q     <= take_bits(sh_q, left_q);
			need_q     <= BIT_COUNT - left_q;
			left_q     <= 4'h0;
			get_pend_q <= 1'b1;
		end else if (up_fill) begin
			sh_q       <= FETCH_DATA << need_q;
			left_q     <= UNPACK_BITS - need_q;
			need_q     <= 4'h0;
			get_pend_q <= 1'b0;
		end
	end

	// Extract result and completion pulse
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			get_data_q <= 8'h00;
			get_done_q <= 1'b0;
		end else if (get_go && get_short) begin
			get_data_q <= take_bits(sh_q, BIT_COUNT);
			get_done_q <= 1'b1;
		end else if (up_fill && get_pend_q) begin
			get_data_q <= (part_q << need_q) |
				take_bits(FETCH_DATA, need_q);
			get_done_q <= 1'b1;
		end else
			get_done_q <= 1'b0;
	end

	assign GET_DATA = get_data_q;
	assign GET_DONE = get_done_q;
endmodule // scaux_top
